/* verilog/deas_pkg.sv */
// constants and types shared by the data nonvolatile access sequencer.
// assumes one 40 MHz system clock; cycle timing is counted in 1 us ticks.
package deas_pkg;
  // control register bit positions
  localparam int B_TSEL = 7;
  localparam int B_ERASE_ENABLE_BIT = 6;
  localparam int B_ERT = 5;
  localparam int B_MODE = 4;
  localparam int B_WRITE_ENABLE_BIT = 3;
  localparam int B_WRT = 2;
  localparam int B_READ_ENABLE_BIT = 1;
  localparam int B_RDT = 0;
  localparam int CTRL_W = 8;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // address layout: 6-bit page over a 4-bit offset
  localparam int PAGE_BITS = 6;
  localparam int OFS_BITS = 4;
  localparam int ADDR_W = PAGE_BITS + OFS_BITS;
  localparam int AH_W = ADDR_W - 8;
  localparam int PAGE_BYTES = 16;
  localparam logic [3:0] OFS_MAX = 4'hf;
  localparam logic [3:0] OFS_ONE = 4'h1;
  // timing
  localparam int CLK_NS = 25;
  localparam int US_NS = 1000;
  localparam int TICK_DIV = US_NS / CLK_NS;
  localparam int ERASE_T0_US = 3200; // 3.2 ms
  localparam int WRITE_T0_US = 2200; // 2.2 ms
  localparam int ERASE_T1_US = 3700; // 3.7 ms
  localparam int WRITE_T1_US = 3000; // 3.0 ms
  localparam int TMR_W = 12;
  localparam int ARM_CYC = 4; // one instruction cycle in system clocks
  localparam int DIV_W = 6;
  localparam int ARM_W = 3;
  typedef enum logic [5:0] {
    DEAS_IDLE = 6'b000001,
    DEAS_READ = 6'b000010,
    DEAS_ERASE = 6'b000100,
    DEAS_WERASE = 6'b001000,
    DEAS_PROG = 6'b010000,
    DEAS_FIN = 6'b100000
  } deas_state_t;
endpackage

/* verilog/deas_top.sv */
// data nonvolatile access sequencer with its own byte storage array.
// assumes cpu-side strobes are synchronous to ref_clk, one cycle each.
`timescale 1ns/1ps
`default_nettype none

// Function
// - byte mode: read trigger starts a read only if read enable already high
// - read end clears read trigger and holds fetched byte in data register
// - page mode: each read trigger fetches one byte then advances address by one
// - page number never increments; 4-bit offset saturates at 0fh, no wrap
// - page buffer cleared at reset and when erase enable falls, not rises
// - erase setup: each dummy data write marks address and advances offset
// - erase starts only when enable then trigger come back to back
// - erase timed internally; end clears trigger, flags done, then drops enable
// - erased page bytes read back as zero
// - byte write needs enable then trigger consecutively; trigger ignored otherwise
// - byte write erases target byte first, then programs new value
// - write timed internally; end clears write trigger and signals completion
// - page buffer cleared when write enable falls, not when it rises
// - page write data loads buffer and advances; writes past 0fh discarded
// - page write uses same activation; write end drops write enable
// - control bits 7..0: tsel, erase_enable_bit, ert, mode, write_enable_bit, wrt, read_enable_bit, rdt
// - tsel 0: 3.2ms erase 2.2ms write; 1: 3.7ms erase 3.0ms write
// - each erase or write end sets done flag and shared interrupt request
module deas_top
  import deas_pkg::*;
#(
  parameter int TICK_CYC = TICK_DIV,
  parameter int ARM_WIN = ARM_CYC
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic ctrl_we,
  input wire logic [7:0] ctrl_wdata,
  input wire logic addr_high_we,
  input wire logic addr_low_we,
  input wire logic [7:0] addr_wdata,
  input wire logic data_we,
  input wire logic [7:0] data_wdata,
  input wire logic done_clr,
  output logic [7:0] nvm_control_reg,
  output logic [AH_W-1:0] nvm_addr_high,
  output logic [7:0] nvm_addr_low,
  output logic [7:0] nvm_data_reg,
  output logic nvm_done_flag,
  output logic mfi_req
);
  deas_state_t state;
  logic [7:0] mem [0:(1<<ADDR_W)-1];
  logic [7:0] pbuf [0:PAGE_BYTES-1];
  logic [PAGE_BYTES-1:0] pmask;
  logic pg_sat, arm_er, arm_wr, op_er, er_q, wr_q;
  logic [ARM_W-1:0] arm_age;
  logic [DIV_W-1:0] div_cnt;
  logic [TMR_W-1:0] tmr;

  // decode of address, offset and request qualifiers
  wire logic [ADDR_W-1:0] addr = {nvm_addr_high, nvm_addr_low};
  wire logic [OFS_BITS-1:0] ofs = nvm_addr_low[OFS_BITS-1:0];
  wire logic [PAGE_BITS-1:0] page = addr[ADDR_W-1:OFS_BITS];
  wire logic ofs_at_max = (ofs == OFS_MAX);
  wire logic [OFS_BITS-1:0] ofs_next = ofs_at_max ? ofs : OFS_BITS'(ofs + OFS_ONE);
  wire logic idle = (state == DEAS_IDLE);
  wire logic mode_pg = nvm_control_reg[B_MODE];
  wire logic sw_ctrl = idle && ctrl_we;
  wire logic arm_live = (arm_age < ARM_W'(ARM_WIN));
  wire logic rd_go = sw_ctrl && ctrl_wdata[B_RDT] && nvm_control_reg[B_READ_ENABLE_BIT];
  wire logic er_go = sw_ctrl && ctrl_wdata[B_ERT] && nvm_control_reg[B_ERASE_ENABLE_BIT]
                     && arm_er && arm_live;
  wire logic wr_go = sw_ctrl && ctrl_wdata[B_WRT] && nvm_control_reg[B_WRITE_ENABLE_BIT]
                     && arm_wr && arm_live;
  wire logic tick = (div_cnt == DIV_W'(TICK_CYC - 1));
  wire logic tmr_end = tick && (tmr == TMR_W'(1));
  wire logic buf_clr = (er_q && !nvm_control_reg[B_ERASE_ENABLE_BIT])
                       || (wr_q && !nvm_control_reg[B_WRITE_ENABLE_BIT]);
  wire logic dat_pg = idle && data_we && mode_pg;
  wire logic dat_take = dat_pg && !pg_sat;
  wire logic [7:0] rd_byte = mem[addr];
  wire logic [TMR_W-1:0] er_time = nvm_control_reg[B_TSEL] ?
                                   TMR_W'(ERASE_T1_US) : TMR_W'(ERASE_T0_US);
  wire logic [TMR_W-1:0] wr_time = nvm_control_reg[B_TSEL] ?
                                   TMR_W'(WRITE_T1_US) : TMR_W'(WRITE_T0_US);

  // free-running microsecond divider stands in for the independent cycle timer
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) div_cnt <= '0;
    else div_cnt <= tick ? '0 : DIV_W'(div_cnt + 1'b1);
  end

  // activation window: a trigger must follow the enable on the very next write
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      arm_er <= 1'b0;
      arm_wr <= 1'b0;
      arm_age <= '0;
    end else if (sw_ctrl) begin
      arm_er <= ctrl_wdata[B_ERASE_ENABLE_BIT] && !nvm_control_reg[B_ERASE_ENABLE_BIT];
      arm_wr <= ctrl_wdata[B_WRITE_ENABLE_BIT] && !nvm_control_reg[B_WRITE_ENABLE_BIT];
      arm_age <= '0;
    end else if (arm_live) begin
      arm_age <= ARM_W'(arm_age + 1'b1);
    end
  end

  // sequencer and control register; cpu writes are ignored while busy
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= DEAS_IDLE;
      nvm_control_reg <= CTRL_RST;
      tmr <= '0;
      op_er <= 1'b0;
    end else begin
      unique case (state)
        DEAS_IDLE: begin
          if (sw_ctrl) begin
            nvm_control_reg <= ctrl_wdata;
            nvm_control_reg[B_RDT] <= rd_go;
            nvm_control_reg[B_ERT] <= er_go;
            nvm_control_reg[B_WRT] <= wr_go;
          end
          op_er <= er_go;
          if (rd_go) state <= DEAS_READ;
          else if (er_go) begin
            tmr <= er_time;
            state <= DEAS_ERASE;
          end else if (wr_go) begin
            tmr <= wr_time;
            state <= mode_pg ? DEAS_PROG : DEAS_WERASE;
          end
        end
        DEAS_READ: begin
          nvm_control_reg[B_RDT] <= 1'b0;
          state <= DEAS_IDLE;
        end
        DEAS_WERASE: state <= DEAS_PROG;
        DEAS_ERASE, DEAS_PROG: begin
          if (tick) tmr <= TMR_W'(tmr - 1'b1);
          if (tmr_end) begin
            nvm_control_reg[B_ERT] <= 1'b0;
            nvm_control_reg[B_WRT] <= 1'b0;
            state <= DEAS_FIN;
          end
        end
        DEAS_FIN: begin
          // enable drops one cycle after the done flag rises
          if (op_er) nvm_control_reg[B_ERASE_ENABLE_BIT] <= 1'b0;
          else nvm_control_reg[B_WRITE_ENABLE_BIT] <= 1'b0;
          state <= DEAS_IDLE;
        end
        default: state <= DEAS_IDLE;
      endcase
    end
  end

  // address registers: cpu loads, hardware advances only the offset
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      nvm_addr_high <= '0;
      nvm_addr_low <= '0;
      pg_sat <= 1'b0;
    end else if (idle && addr_high_we) begin
      nvm_addr_high <= addr_wdata[AH_W-1:0];
    end else if (idle && addr_low_we) begin
      nvm_addr_low <= addr_wdata;
      pg_sat <= 1'b0;
    end else if ((state == DEAS_READ && mode_pg) || dat_take) begin
      nvm_addr_low[OFS_BITS-1:0] <= ofs_next;
      pg_sat <= ofs_at_max && dat_take;
    end
  end

  // data register holds the last read or the last cpu write
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) nvm_data_reg <= '0;
    else if (state == DEAS_READ) nvm_data_reg <= rd_byte;
    else if (idle && data_we) nvm_data_reg <= data_wdata;
  end

  // page buffer marks; cleared on an enable falling edge, seen one cycle late
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pmask <= '0;
      er_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      er_q <= nvm_control_reg[B_ERASE_ENABLE_BIT];
      wr_q <= nvm_control_reg[B_WRITE_ENABLE_BIT];
      if (buf_clr) pmask <= '0;
      else if (dat_take) pmask[ofs] <= 1'b1;
    end
  end

  // buffer bytes and storage array carry no reset, as a real array
  always_ff @(posedge ref_clk) begin
    if (dat_take) pbuf[ofs] <= data_wdata;
    if (state == DEAS_WERASE) mem[addr] <= 8'h00;
    for (int i = 0; i < PAGE_BYTES; i++) begin
      if (state == DEAS_ERASE && tmr_end && pmask[i])
        mem[{page, OFS_BITS'(i)}] <= 8'h00;
      if (state == DEAS_PROG && tmr_end && mode_pg && pmask[i])
        mem[{page, OFS_BITS'(i)}] <= pbuf[i];
    end
    if (state == DEAS_PROG && tmr_end && !mode_pg) mem[addr] <= nvm_data_reg;
  end

  // completion flag is sticky; a new completion beats a same-cycle clear
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      nvm_done_flag <= 1'b0;
      mfi_req <= 1'b0;
    end else begin
      nvm_done_flag <= (tmr_end && !idle) || (nvm_done_flag && !done_clr);
      mfi_req <= tmr_end && (state == DEAS_ERASE || state == DEAS_PROG);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  chk_read_needs_en: assert property (
    sw_ctrl && ctrl_wdata[B_RDT] && !nvm_control_reg[B_READ_ENABLE_BIT]
    |=> !nvm_control_reg[B_RDT] && state == DEAS_IDLE) else $error("read ran without enable");
  chk_read_result: assert property (
    state == DEAS_READ |=> !nvm_control_reg[B_RDT] && nvm_data_reg == $past(rd_byte))
    else $error("read result");
  chk_page_advance: assert property (
    state == DEAS_READ && mode_pg && !ofs_at_max
    |=> ofs == OFS_BITS'($past(ofs) + OFS_ONE)) else $error("page offset not advanced");
  chk_offset_sat: assert property (
    (state == DEAS_READ || dat_take) && ofs_at_max
    |=> ofs == OFS_MAX && $stable(page)) else $error("offset wrapped");
  chk_buf_cleared: assert property (
    buf_clr |=> pmask == '0) else $error("buffer kept");
  // a trigger outside the live window must be refused as well as an unarmed one
  chk_erase_arm: assert property (
    sw_ctrl && ctrl_wdata[B_ERT] && !(arm_er && arm_live)
    |=> state != DEAS_ERASE) else $error("erase without arming");
  chk_erase_end: assert property (
    state == DEAS_ERASE && tmr_end
    |=> !nvm_control_reg[B_ERT] && nvm_done_flag && mfi_req ##1 !nvm_control_reg[B_ERASE_ENABLE_BIT])
    else $error("erase end order");
  chk_write_end: assert property (
    state == DEAS_PROG && tmr_end
    |=> !nvm_control_reg[B_WRT] && nvm_done_flag && mfi_req ##1 !nvm_control_reg[B_WRITE_ENABLE_BIT])
    else $error("write end order");
  chk_full_discard: assert property (
    dat_pg && pg_sat |=> $stable(pmask) && $stable(addr))
    else $error("write past page end taken");
  chk_byte_data: assert property (
    idle && data_we && !mode_pg && !addr_low_we && !addr_high_we
    |=> $stable(addr) && nvm_data_reg == $past(data_wdata)) else $error("byte data");
  cov_byte_read: cover property (rd_go && !mode_pg ##1 state == DEAS_READ);
  cov_page_erase: cover property (state == DEAS_ERASE && tmr_end && pmask != '0);
  cov_page_write: cover property (state == DEAS_PROG && tmr_end && mode_pg);
  cov_byte_write: cover property (state == DEAS_WERASE);
endmodule
`default_nettype wire

/* bench/deas_ref_mem.sv */
// reference copy of the byte storage array behind the sequencer.
// assumes the bench calls its tasks whenever it starts an erase or write.
`timescale 1ns/1ps
`default_nettype none
module deas_ref_mem;
  logic [7:0] mem [0:1023];

  // byte write zeroes the target byte first, then programs it
  task automatic prog(input logic [9:0] a, input logic [7:0] d);
    mem[a] = 8'h00;
    mem[a] = d;
  endtask

  // page erase leaves every byte of the page at zero
  task automatic erase_page(input logic [5:0] p);
    for (int i = 0; i < 16; i++) begin
      mem[{p, 4'(i)}] = 8'h00;
    end
  endtask
endmodule
`default_nettype wire

/* bench/tb_top.sv */
// directed bench for the sequencer: byte and page read, erase and write.
// assumes a shortened timer tick of 2 clocks per microsecond.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import deas_pkg::*;
  localparam int TK = 2;
  logic ref_clk = 1'b0, arst_n = 1'b0, ctrl_we = 1'b0, addr_high_we = 1'b0;
  logic addr_low_we = 1'b0, data_we = 1'b0, done_clr = 1'b0;
  logic [7:0] ctrl_wdata = 8'h00, addr_wdata = 8'h00, data_wdata = 8'h00;
  logic [7:0] nvm_control_reg, nvm_addr_low, nvm_data_reg;
  logic [AH_W-1:0] nvm_addr_high;
  logic nvm_done_flag, mfi_req;
  int num_errors = 0, n_checks = 0, n_mfi = 0, cyc = 0, t;

  deas_top #(.TICK_CYC(TK), .ARM_WIN(ARM_CYC)) i_dut (.ref_clk(ref_clk), .arst_n(arst_n),
    .ctrl_we(ctrl_we), .ctrl_wdata(ctrl_wdata), .addr_high_we(addr_high_we),
    .addr_low_we(addr_low_we), .addr_wdata(addr_wdata), .data_we(data_we),
    .data_wdata(data_wdata), .done_clr(done_clr), .nvm_control_reg(nvm_control_reg),
    .nvm_addr_high(nvm_addr_high), .nvm_addr_low(nvm_addr_low), .nvm_data_reg(nvm_data_reg),
    .nvm_done_flag(nvm_done_flag), .mfi_req(mfi_req));
  deas_ref_mem i_ref ();

  initial forever #12.5 ref_clk = ~ref_clk;

  // timeout guard; also counts completion pulses
  always @(posedge ref_clk) begin
    cyc++;
    if (mfi_req === 1'b1) n_mfi++;
    if (cyc == 40000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one strobe cycle: 0 ctrl, 1 addr high, 2 addr low, 3 data, 4 done clear
  task automatic strobe(input int k, input logic [7:0] v);
    @(posedge ref_clk);
    ctrl_wdata <= v;
    addr_wdata <= v;
    data_wdata <= v;
    ctrl_we <= (k == 0);
    addr_high_we <= (k == 1);
    addr_low_we <= (k == 2);
    data_we <= (k == 3);
    done_clr <= (k == 4);
    @(posedge ref_clk);
    {ctrl_we, addr_high_we, addr_low_we, data_we, done_clr} <= 5'h00;
  endtask

  task automatic set_addr(input logic [9:0] a);
    strobe(1, {6'h00, a[9:8]});
    strobe(2, a[7:0]);
  endtask

  // bounded wait for a trigger bit to self-clear; returns cycles waited
  task automatic wait_clr(input int b, output int c);
    c = 0;
    @(negedge ref_clk);
    while (nvm_control_reg[b] !== 1'b0 && c < 20000) begin
      @(negedge ref_clk);
      c++;
    end
  endtask

  task automatic rd(input logic [7:0] m, input logic [7:0] exp);
    strobe(0, m | 8'h03);
    wait_clr(B_RDT, t);
    check("read data", nvm_data_reg, exp);
  endtask

  // page read of page 2 from offset 0, one trigger per byte
  task automatic rd_page();
    set_addr(10'h020);
    strobe(0, 8'h12);
    for (int i = 0; i < 16; i++) rd(8'h10, i_ref.mem[10'h020 + i]);
    check("page read stop", {nvm_addr_high, nvm_addr_low}, 16'h002f);
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(negedge ref_clk);
    check("ctrl reset", nvm_control_reg, CTRL_RST);
    strobe(0, 8'h01);
    @(negedge ref_clk);
    check("read trigger alone", nvm_control_reg, 8'h00);
    strobe(0, 8'h04);
    @(negedge ref_clk);
    check("write trigger alone", nvm_control_reg, 8'h00);
    // byte write with the long timing
    set_addr(10'h025);
    strobe(3, 8'ha5);
    i_ref.prog(10'h025, 8'ha5);
    check("byte addr kept", {nvm_addr_high, nvm_addr_low}, 16'h0025);
    strobe(0, 8'h88);
    strobe(0, 8'h8c);
    @(negedge ref_clk);
    check("write armed", nvm_control_reg, 8'h8c);
    wait_clr(B_WRT, t);
    check("write time", (t >= WRITE_T1_US * TK - 8 && t <= WRITE_T1_US * TK + 8), 1);
    check("write done", nvm_done_flag, 1'b1);
    repeat (2) @(negedge ref_clk);
    check("write_enable_bit drop", nvm_control_reg, 8'h80);
    strobe(4, 8'h00);
    @(negedge ref_clk);
    check("done cleared", nvm_done_flag, 1'b0);
    strobe(0, 8'h02);
    rd(8'h00, 8'ha5);
    // late erase trigger is refused
    strobe(0, 8'h50);
    repeat (8) @(posedge ref_clk);
    strobe(0, 8'h70);
    @(negedge ref_clk);
    check("late trigger", nvm_control_reg, 8'h50);
    // page erase of page 2, 17 dummy writes saturate at offset 0f
    strobe(0, 8'h10);
    set_addr(10'h020);
    for (int i = 0; i < 17; i++) strobe(3, 8'hff);
    check("erase offset", {nvm_addr_high, nvm_addr_low}, 16'h002f);
    i_ref.erase_page(6'h02);
    strobe(0, 8'h50);
    strobe(0, 8'h70);
    wait_clr(B_ERT, t);
    check("erase time", (t >= ERASE_T0_US * TK - 8 && t <= ERASE_T0_US * TK + 8), 1);
    repeat (2) @(negedge ref_clk);
    check("erase_enable_bit drop", nvm_control_reg, 8'h10);
    rd_page();
    // page write into the page erased above; the seventeenth byte is discarded
    // interrupts are taken as masked: nothing runs between enable and trigger
    strobe(0, 8'h10);
    set_addr(10'h020);
    for (int i = 0; i < 17; i++) begin
      strobe(3, 8'h30 + 8'(i));
      if (i < 16) i_ref.prog(10'h020 + i, 8'h30 + 8'(i));
    end
    strobe(0, 8'h18);
    strobe(0, 8'h1c);
    wait_clr(B_WRT, t);
    repeat (2) @(negedge ref_clk);
    check("page write_enable_bit drop", nvm_control_reg, 8'h10);
    rd_page();
    check("irq pulses", n_mfi, 3);
    print_verdict();
  end
endmodule
`default_nettype wire
